// file: design/mbag_path.sv
// Effective address and pointer update for one address generator
`timescale 1ns/1ps
`default_nettype none
module mbag_path (
   // Request
   input  wire logic        [15:0] ptr,
   input  wire logic        [15:0] step,
   input  wire logic        [2:0]  mode,
   // Circular and reversal controls
   input  wire logic               circ_on,
   input  wire logic        [15:0] buf_start,
   input  wire logic        [15:0] buf_end,
   input  wire logic               word_only,
   input  wire logic               rev_on,
   input  wire logic        [15:0] rev_mod,
   // Result
   output logic             [15:0] ea,
   output logic                    wb_en,
   output logic             [15:0] wb_val,
   output logic                    wrapped
);

   function automatic logic [15:0] mirror(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15-i];
      end
      return r;
   endfunction

   logic        up;
   logic        moved;
   logic [15:0] mod_val;
   logic [15:0] len;
   logic [15:0] fixed;

   always_comb begin
      up      = 1'b0;
      moved   = 1'b1;
      mod_val = ptr;
      ea      = ptr;
      wb_en   = 1'b0;
      wrapped = 1'b0;
      len     = buf_end - buf_start + 16'h0001;
      unique case (mode)
         mbag_pkg::MODE_POST_INC, mbag_pkg::MODE_PRE_INC: begin
            up = 1'b1;
            // Carry runs from the high bit downward: pointer and modifier are mirrored, added, and the sum mirrored back
            if (rev_on) begin
               mod_val = mirror(mirror(ptr) + mirror(rev_mod));
            end else begin
               mod_val = ptr + step;
            end
         end
         mbag_pkg::MODE_POST_DEC, mbag_pkg::MODE_PRE_DEC: begin
            mod_val = ptr - step;
         end
         mbag_pkg::MODE_OFFSET: begin
            up      = ~step[15];
            mod_val = ptr + step;
         end
         default: begin
            // Unmodified pointer: no boundary check, no wrap report
            moved   = 1'b0;
            mod_val = ptr;
         end
      endcase
      fixed = mod_val;
      if (circ_on && moved && up && (mod_val > buf_end)) begin
         fixed   = mod_val - len;
         wrapped = 1'b1;
      end else if (circ_on && moved && !up && (mod_val < buf_start)) begin
         fixed   = mod_val + len;
         wrapped = 1'b1;
      end
      if (word_only) begin
         fixed[0] = 1'b0;
      end
      unique case (mode)
         mbag_pkg::MODE_PRE_INC, mbag_pkg::MODE_PRE_DEC: begin
            ea    = fixed;
            wb_en = 1'b1;
         end
         mbag_pkg::MODE_POST_INC, mbag_pkg::MODE_POST_DEC: begin
            ea    = ptr;
            wb_en = 1'b1;
         end
         mbag_pkg::MODE_OFFSET: begin
            ea    = fixed;
            wb_en = 1'b0;
         end
         default: begin
            ea    = ptr;
            wb_en = 1'b0;
         end
      endcase
      wb_val = fixed;
   end

endmodule // mbag_path
`default_nettype wire

// file: design/mbag_pkg.sv
// Package: constants and types for the modulo and bit-reversed address generator
package mbag_pkg;

   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_ADDRESS_MODE_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_REVERSAL_MODIFIER_CONTROL = 8'h04;
   localparam logic [7:0] OFS_X_BUFFER_START            = 8'h08;
   localparam logic [7:0] OFS_X_BUFFER_END              = 8'h0C;
   localparam logic [7:0] OFS_Y_BUFFER_START            = 8'h10;
   localparam logic [7:0] OFS_Y_BUFFER_END              = 8'h14;
   localparam logic [7:0] OFS_STATUS                    = 8'h18;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int X_SEL_LSB       = 0;
   localparam int Y_SEL_LSB       = 4;
   localparam int REV_SEL_LSB     = 8;
   localparam int Y_CIRC_EN_BIT   = 14;
   localparam int X_CIRC_EN_BIT   = 15;
   localparam int REV_EN_BIT      = 15;
   localparam int ST_XR_WRAP_BIT  = 0;
   localparam int ST_XW_WRAP_BIT  = 1;
   localparam int ST_Y_WRAP_BIT   = 2;
   localparam int ST_XW_REV_BIT   = 3;

   // Pointer select value that disables a feature
   localparam logic [3:0] SEL_DISABLED = 4'hF;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_ADDRESS_MODE_CONTROL      = 16'h0FFF;
   localparam logic [15:0] RST_REVERSAL_MODIFIER_CONTROL = 16'h0000;
   localparam logic [15:0] RST_BUFFER_BOUND              = 16'h0000;

   // ---------------------------------------------------------------
   // Addressing modes supplied by the execute path
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INDIRECT = 3'b000,
      MODE_POST_INC = 3'b001,
      MODE_POST_DEC = 3'b010,
      MODE_PRE_INC  = 3'b011,
      MODE_PRE_DEC  = 3'b100,
      MODE_OFFSET   = 3'b101
   } mbag_mode_t;

endpackage

// file: design/mbag_top.sv
// Top: modulo and bit-reversed address generator with APB registers
// Function
// - Y select of 15 turns circular correction off in Y.
// - X select in bits 3:0; X circular needs select not 15 and bit 15.
// - Y select in bits 7:4; Y circular needs select not 15 and bit 14.
// - Limits trip on addresses beyond them, not only equal.
// - Corrected address written back only for pre- or post-modify.
// - Register-plus-offset is corrected but leaves the pointer unchanged.
// - Reversal only in the X write generator.
// - Only the modifier is bit-reversed; addresses stay in normal order.
// - Reversal needs select not 15, enable bit 15, indirect pre/post increment.
// - Modifier scaled to bytes; reversed addresses have bit 0 clear.
// - Byte access or other modes give normal addresses.
// - Reversal adds the modifier instead of the step and clears bit 0.
// - Reversal beats circular in X write; X read stays circular.
// - A 16-entry buffer walks indices in mirrored bit order.
// - Limits come from separate 16-bit start and end registers per space.
// - Y circular addresses assume words; bit 0 is clear.
// - One circular buffer in X and one in Y.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mbag_top (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // X read request
   input  wire logic        xr_req,
   input  wire logic [3:0]  xr_sel,
   input  wire logic [15:0] xr_ptr,
   input  wire logic [2:0]  xr_mode,
   input  wire logic [15:0] xr_step,
   // X read answer
   output logic             xr_done,
   output logic      [15:0] xr_ea,
   output logic             xr_wb_en,
   output logic      [15:0] xr_wb_val,
   // X write request
   input  wire logic        xw_req,
   input  wire logic [3:0]  xw_sel,
   input  wire logic [15:0] xw_ptr,
   input  wire logic [2:0]  xw_mode,
   input  wire logic [15:0] xw_step,
   input  wire logic        xw_byte,
   // X write answer
   output logic             xw_done,
   output logic      [15:0] xw_ea,
   output logic             xw_wb_en,
   output logic      [15:0] xw_wb_val,
   // Y request
   input  wire logic        y_req,
   input  wire logic [3:0]  y_sel,
   input  wire logic [15:0] y_ptr,
   input  wire logic [2:0]  y_mode,
   input  wire logic [15:0] y_step,
   // Y answer
   output logic             y_done,
   output logic      [15:0] y_ea,
   output logic             y_wb_en,
   output logic      [15:0] y_wb_val
);

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [15:0] address_mode_control_reg;
   logic [15:0] address_mode_control_next;
   logic [15:0] reversal_modifier_control_reg;
   logic [15:0] reversal_modifier_control_next;
   logic [15:0] x_buffer_start_reg;
   logic [15:0] x_buffer_start_next;
   logic [15:0] x_buffer_end_reg;
   logic [15:0] x_buffer_end_next;
   logic [15:0] y_buffer_start_reg;
   logic [15:0] y_buffer_start_next;
   logic [15:0] y_buffer_end_reg;
   logic [15:0] y_buffer_end_next;
   logic [3:0]  status_reg;
   logic [3:0]  status_next;

   // ---------------------------------------------------------------
   // APB slave: one wait state, answer from flip-flops
   // ---------------------------------------------------------------
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   logic        addr_hit;
   logic [15:0] rd_word;
   logic        wr_commit;

   always_comb begin
      addr_hit = 1'b1;
      rd_word  = 16'h0000;
      unique case (paddr)
         mbag_pkg::OFS_ADDRESS_MODE_CONTROL:      rd_word = address_mode_control_reg;
         mbag_pkg::OFS_REVERSAL_MODIFIER_CONTROL: rd_word = reversal_modifier_control_reg;
         mbag_pkg::OFS_X_BUFFER_START:            rd_word = x_buffer_start_reg;
         mbag_pkg::OFS_X_BUFFER_END:              rd_word = x_buffer_end_reg;
         mbag_pkg::OFS_Y_BUFFER_START:            rd_word = y_buffer_start_reg;
         mbag_pkg::OFS_Y_BUFFER_END:              rd_word = y_buffer_end_reg;
         mbag_pkg::OFS_STATUS:                    rd_word = {12'h000, status_reg};
         default: begin
            addr_hit = 1'b0;
            rd_word  = 16'h0000;
         end
      endcase
      pready_next  = psel & penable & ~pready_reg;
      pslverr_next = psel & penable & ~pready_reg & ~addr_hit;
      prdata_next  = prdata_reg;
      if (psel && penable && !pready_reg) begin
         prdata_next = (!pwrite && addr_hit) ? {16'h0000, rd_word} : 32'h0000_0000;
      end
      wr_commit = psel & penable & pready_reg & pwrite & addr_hit;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_comb begin
      address_mode_control_next      = address_mode_control_reg;
      reversal_modifier_control_next = reversal_modifier_control_reg;
      x_buffer_start_next            = x_buffer_start_reg;
      x_buffer_end_next              = x_buffer_end_reg;
      y_buffer_start_next            = y_buffer_start_reg;
      y_buffer_end_next              = y_buffer_end_reg;
      if (wr_commit) begin
         unique case (paddr)
            mbag_pkg::OFS_ADDRESS_MODE_CONTROL:      address_mode_control_next = pwdata[15:0];
            mbag_pkg::OFS_REVERSAL_MODIFIER_CONTROL: reversal_modifier_control_next = pwdata[15:0];
            mbag_pkg::OFS_X_BUFFER_START:            x_buffer_start_next = pwdata[15:0];
            mbag_pkg::OFS_X_BUFFER_END:              x_buffer_end_next = pwdata[15:0];
            mbag_pkg::OFS_Y_BUFFER_START:            y_buffer_start_next = pwdata[15:0];
            mbag_pkg::OFS_Y_BUFFER_END:              y_buffer_end_next = pwdata[15:0];
            default: begin
               address_mode_control_next = address_mode_control_reg;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_mode_control_reg      <= mbag_pkg::RST_ADDRESS_MODE_CONTROL;
         reversal_modifier_control_reg <= mbag_pkg::RST_REVERSAL_MODIFIER_CONTROL;
         x_buffer_start_reg            <= mbag_pkg::RST_BUFFER_BOUND;
         x_buffer_end_reg              <= mbag_pkg::RST_BUFFER_BOUND;
         y_buffer_start_reg            <= mbag_pkg::RST_BUFFER_BOUND;
         y_buffer_end_reg              <= mbag_pkg::RST_BUFFER_BOUND;
      end else begin
         address_mode_control_reg      <= address_mode_control_next;
         reversal_modifier_control_reg <= reversal_modifier_control_next;
         x_buffer_start_reg            <= x_buffer_start_next;
         x_buffer_end_reg              <= x_buffer_end_next;
         y_buffer_start_reg            <= y_buffer_start_next;
         y_buffer_end_reg              <= y_buffer_end_next;
      end
   end

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   logic [3:0]  x_circular_pointer_select;
   logic [3:0]  y_circular_pointer_select;
   logic [3:0]  reversal_pointer_select;
   logic        x_circular_enable;
   logic        y_circular_enable;
   logic        reversal_enable;
   logic [15:0] reversal_modifier;
   logic        x_circ_act;
   logic        y_circ_act;
   logic        xw_incr;
   logic        xw_rev;
   logic        xr_circ;
   logic        xw_circ;
   logic        y_circ;

   always_comb begin
      x_circular_pointer_select = address_mode_control_reg[mbag_pkg::X_SEL_LSB +: 4];
      y_circular_pointer_select = address_mode_control_reg[mbag_pkg::Y_SEL_LSB +: 4];
      reversal_pointer_select   = address_mode_control_reg[mbag_pkg::REV_SEL_LSB +: 4];
      x_circular_enable         = address_mode_control_reg[mbag_pkg::X_CIRC_EN_BIT];
      y_circular_enable         = address_mode_control_reg[mbag_pkg::Y_CIRC_EN_BIT];
      reversal_enable           = reversal_modifier_control_reg[mbag_pkg::REV_EN_BIT];
      // Modifier in words, shifted to a byte step
      reversal_modifier         = {reversal_modifier_control_reg[14:0], 1'b0};
      x_circ_act = x_circular_enable &&
                   (x_circular_pointer_select != mbag_pkg::SEL_DISABLED);
      y_circ_act = y_circular_enable &&
                   (y_circular_pointer_select != mbag_pkg::SEL_DISABLED);
      xw_incr    = (xw_mode == mbag_pkg::MODE_PRE_INC) || (xw_mode == mbag_pkg::MODE_POST_INC);
      xw_rev     = reversal_enable && xw_incr && !xw_byte &&
                   (reversal_pointer_select != mbag_pkg::SEL_DISABLED) &&
                   (xw_sel == reversal_pointer_select);
      xr_circ    = x_circ_act && (xr_sel == x_circular_pointer_select);
      xw_circ    = x_circ_act && (xw_sel == x_circular_pointer_select) && !xw_rev;
      y_circ     = y_circ_act && (y_sel == y_circular_pointer_select);
   end

   // ---------------------------------------------------------------
   // Address generators
   // ---------------------------------------------------------------
   logic [15:0] xr_ea_c;
   logic        xr_wb_en_c;
   logic [15:0] xr_wb_val_c;
   logic        xr_wrap_c;
   logic [15:0] xw_ea_c;
   logic        xw_wb_en_c;
   logic [15:0] xw_wb_val_c;
   logic        xw_wrap_c;
   logic [15:0] y_ea_c;
   logic        y_wb_en_c;
   logic [15:0] y_wb_val_c;
   logic        y_wrap_c;

   mbag_path u_xr (
      .ptr       (xr_ptr),
      .step      (xr_step),
      .mode      (xr_mode),
      .circ_on   (xr_circ),
      .buf_start (x_buffer_start_reg),
      .buf_end   (x_buffer_end_reg),
      .word_only (1'b0),
      .rev_on    (1'b0),
      .rev_mod   (reversal_modifier),
      .ea        (xr_ea_c),
      .wb_en     (xr_wb_en_c),
      .wb_val    (xr_wb_val_c),
      .wrapped   (xr_wrap_c)
   );

   mbag_path u_xw (
      .ptr       (xw_ptr),
      .step      (xw_step),
      .mode      (xw_mode),
      .circ_on   (xw_circ),
      .buf_start (x_buffer_start_reg),
      .buf_end   (x_buffer_end_reg),
      .word_only (xw_rev),
      .rev_on    (xw_rev),
      .rev_mod   (reversal_modifier),
      .ea        (xw_ea_c),
      .wb_en     (xw_wb_en_c),
      .wb_val    (xw_wb_val_c),
      .wrapped   (xw_wrap_c)
   );

   mbag_path u_y (
      .ptr       (y_ptr),
      .step      (y_step),
      .mode      (y_mode),
      .circ_on   (y_circ),
      .buf_start (y_buffer_start_reg),
      .buf_end   (y_buffer_end_reg),
      .word_only (y_circ),
      .rev_on    (1'b0),
      .rev_mod   (reversal_modifier),
      .ea        (y_ea_c),
      .wb_en     (y_wb_en_c),
      .wb_val    (y_wb_val_c),
      .wrapped   (y_wrap_c)
   );

   // ---------------------------------------------------------------
   // Registered answers and status
   // ---------------------------------------------------------------
   logic [33:0] xr_out_reg;
   logic [33:0] xr_out_next;
   logic [33:0] xw_out_reg;
   logic [33:0] xw_out_next;
   logic [33:0] y_out_reg;
   logic [33:0] y_out_next;

   always_comb begin
      xr_out_next = {xr_req, xr_ea_c, xr_req & xr_wb_en_c, xr_wb_val_c};
      xw_out_next = {xw_req, xw_ea_c, xw_req & xw_wb_en_c, xw_wb_val_c};
      y_out_next  = {y_req, y_ea_c, y_req & y_wb_en_c, y_wb_val_c};
      status_next = status_reg;
      if (xr_req) begin
         status_next[mbag_pkg::ST_XR_WRAP_BIT] = xr_wrap_c;
      end
      if (xw_req) begin
         status_next[mbag_pkg::ST_XW_WRAP_BIT] = xw_wrap_c;
         status_next[mbag_pkg::ST_XW_REV_BIT]  = xw_rev;
      end
      if (y_req) begin
         status_next[mbag_pkg::ST_Y_WRAP_BIT] = y_wrap_c;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xr_out_reg <= '0;
         xw_out_reg <= '0;
         y_out_reg  <= '0;
         status_reg <= 4'h0;
      end else begin
         xr_out_reg <= xr_out_next;
         xw_out_reg <= xw_out_next;
         y_out_reg  <= y_out_next;
         status_reg <= status_next;
      end
   end

   assign {xr_done, xr_ea, xr_wb_en, xr_wb_val} = xr_out_reg;
   assign {xw_done, xw_ea, xw_wb_en, xw_wb_val} = xw_out_reg;
   assign {y_done, y_ea, y_wb_en, y_wb_val}     = y_out_reg;

endmodule // mbag_top
`default_nettype wire

// file: verification/mbag_checker.sv
// Port-level assertions for the address generator top
`timescale 1ns/1ps
`default_nettype none
module mbag_checker (
   // Clock, reset and APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Generators
   input  wire logic        xr_req,
   input  wire logic [2:0]  xr_mode,
   input  wire logic [15:0] xr_ptr,
   input  wire logic        xr_done,
   input  wire logic [15:0] xr_ea,
   input  wire logic        xr_wb_en,
   input  wire logic        xw_req,
   input  wire logic [2:0]  xw_mode,
   input  wire logic [15:0] xw_ptr,
   input  wire logic        xw_done,
   input  wire logic [15:0] xw_ea,
   input  wire logic        xw_wb_en,
   input  wire logic        y_req,
   input  wire logic [2:0]  y_mode,
   input  wire logic        y_done,
   input  wire logic        y_wb_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_xr_mod; xr_req && xr_mode inside {[1:4]} |=> xr_done && xr_wb_en; endproperty
   a_xr_mod: assert property (p_xr_mod) else $error("x read modify lacks write-back");
   property p_xr_ind; xr_req && xr_mode == 3'h0 |=> !xr_wb_en && xr_ea == $past(xr_ptr);
   endproperty
   a_xr_ind: assert property (p_xr_ind) else $error("x read indirect wrong");
   property p_xr_off; xr_req && xr_mode == 3'h5 |=> xr_done && !xr_wb_en; endproperty
   a_xr_off: assert property (p_xr_off) else $error("x read offset wrote back");
   property p_xr_post; xr_req && xr_mode == 3'h1 |=> xr_ea == $past(xr_ptr); endproperty
   a_xr_post: assert property (p_xr_post) else $error("x read post address wrong");
   property p_xw_post; xw_req && xw_mode inside {1, 2} |=> xw_done && xw_ea == $past(xw_ptr);
   endproperty
   a_xw_post: assert property (p_xw_post) else $error("x write post address wrong");
   property p_xw_off; xw_req && xw_mode == 3'h5 |=> !xw_wb_en; endproperty
   a_xw_off: assert property (p_xw_off) else $error("x write offset wrote back");
   property p_y_mod; y_req && y_mode inside {[1:4]} |=> y_done && y_wb_en; endproperty
   a_y_mod: assert property (p_y_mod) else $error("y modify lacks write-back");
   property p_apb; psel && penable && !pready |=> pready; endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
   property p_err; pslverr |-> pready && psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   c_xr_wb: cover property (xr_done && xr_wb_en);
   c_xw_wb: cover property (xw_done && xw_wb_en);
   c_err: cover property (pslverr);
endmodule // mbag_checker
bind mbag_top mbag_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .xr_req, .xr_mode, .xr_ptr, .xr_done, .xr_ea, .xr_wb_en, .xw_req, .xw_mode, .xw_ptr,
   .xw_done, .xw_ea, .xw_wb_en, .y_req, .y_mode, .y_done, .y_wb_en);
`default_nettype wire

// file: verification/mbag_cpu_model.sv
// CPU-side pointer register model feeding the X write generator
`timescale 1ns/1ps
`default_nettype none
module mbag_cpu_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Pointer load and write-back
   input  wire logic        ld,
   input  wire logic [15:0] ld_val,
   input  wire logic        done,
   input  wire logic        wb_en,
   input  wire logic [15:0] wb_val,
   // Pointer to the generator
   output logic      [15:0] ptr
);
   logic [15:0] ptr_reg;
   logic [15:0] ptr_next;
   assign ptr = ptr_reg;
   always_comb begin
      ptr_next = ptr_reg;
      if (ld) begin
         ptr_next = ld_val;
      end else if (done && wb_en) begin
         ptr_next = wb_val;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ptr_reg <= 16'h0000;
      else ptr_reg <= ptr_next;
   end
endmodule // mbag_cpu_model
`default_nettype wire

// file: verification/mbag_top_bench.sv
// Self-checking bench for the modulo and bit-reversed address generator
`timescale 1ns/1ps
`default_nettype none
module mbag_top_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ld, xb, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  rq, dn, we, md [3];
   logic [3:0]  sl [3];
   logic [15:0] pt [3], st [3], ea [3], wv [3], cptr;
   int          errors, checks;
   mbag_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .xr_req(rq[0]), .xr_sel(sl[0]), .xr_ptr(pt[0]), .xr_mode(md[0]),
      .xr_step(st[0]), .xr_done(dn[0]), .xr_ea(ea[0]), .xr_wb_en(we[0]), .xr_wb_val(wv[0]),
      .xw_req(rq[1]), .xw_sel(sl[1]), .xw_ptr(cptr), .xw_mode(md[1]), .xw_step(st[1]),
      .xw_byte(xb), .xw_done(dn[1]), .xw_ea(ea[1]), .xw_wb_en(we[1]), .xw_wb_val(wv[1]),
      .y_req(rq[2]), .y_sel(sl[2]), .y_ptr(pt[2]), .y_mode(md[2]), .y_step(st[2]),
      .y_done(dn[2]), .y_ea(ea[2]), .y_wb_en(we[2]), .y_wb_val(wv[2]));
   mbag_cpu_model u_cpu (.pclk, .presetn, .ld, .ld_val(pt[1]), .done(dn[1]), .wb_en(we[1]),
      .wb_val(wv[1]), .ptr(cptr));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      if (pready !== 1'b1) begin errors++; finish_test; end
   endtask
   task automatic op(input int g, input logic [3:0] s, input logic [15:0] p,
                     input logic [2:0] m, input logic [15:0] t, input logic b, input logic kp);
      @(posedge pclk);
      if (g == 1 && !kp) begin
         ld <= 1; pt[1] <= p;
         @(posedge pclk);
         ld <= 0;
      end
      rq[g] <= 1; sl[g] <= s; pt[g] <= p; md[g] <= m; st[g] <= t; xb <= b;
      @(posedge pclk);
      rq[g] <= 0;
      #1;
   endtask
   function automatic logic [3:0] rv(input logic [3:0] v);
      return {v[0], v[1], v[2], v[3]};
   endfunction
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      apb(0, 8'h00, 32'h0); chk(rd, 32'h0FFF);
      apb(0, 8'h04, 32'h0); chk(rd, 32'h0);
      apb(1, 8'h08, 32'h1234); apb(0, 8'h08, 32'h0); chk(rd, 32'h1234);
      apb(0, 8'h1C, 32'h0); chk(er, 1'b1);
   endtask
   task automatic t_circ_x;
      apb(1, 8'h08, 32'h1000); apb(1, 8'h0C, 32'h101F); apb(1, 8'h00, 32'h8FF3);
      op(0, 4'h3, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[0], 16'h1002);
      op(0, 4'h3, 16'h1000, 3'h4, 16'h2, 0, 0); chk(ea[0], 16'h101E);
      op(0, 4'h3, 16'h101C, 3'h5, 16'h8, 0, 0); chk(ea[0], 16'h1004);
      op(0, 4'h4, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[0], 16'h1022);
      op(1, 4'h3, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[1], 16'h1002);
      apb(1, 8'h00, 32'h0FF3);
      op(0, 4'h3, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[0], 16'h1022);
      apb(1, 8'h00, 32'h8FFF);
      op(0, 4'hF, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[0], 16'h1022);
      op(1, 4'hF, 16'h101E, 3'h1, 16'h4, 0, 0); chk(wv[1], 16'h1022);
   endtask
   task automatic t_circ_y;
      apb(1, 8'h10, 32'h2000); apb(1, 8'h14, 32'h200F); apb(1, 8'h00, 32'h4F2F);
      op(2, 4'h2, 16'h200E, 3'h1, 16'h2, 0, 0); chk(wv[2], 16'h2000);
      op(2, 4'h2, 16'h2000, 3'h2, 16'h4, 0, 0); chk(wv[2], 16'h200C);
      op(2, 4'h2, 16'h2005, 3'h5, 16'h0, 0, 0); chk(ea[2], 16'h2004);
      apb(1, 8'h00, 32'h4FFF);
      op(2, 4'hF, 16'h200E, 3'h1, 16'h2, 0, 0); chk(wv[2], 16'h2010);
   endtask
   task automatic t_rev;
      apb(1, 8'h08, 32'h4000); apb(1, 8'h0C, 32'h4007); apb(1, 8'h00, 32'h85F5);
      apb(1, 8'h04, 32'h8008);
      @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
         op(1, 4'h5, 16'h4000, 3'h1, 16'h2, 0, i != 0);
         chk(ea[1], {11'h200, rv(i[3:0]), 1'b0});
      end
      apb(0, 8'h18, 32'h0); chk(rd, 32'h8);
      op(1, 4'h5, 16'h4001, 3'h3, 16'h2, 0, 0); chk(ea[1], 16'h4010);
      op(1, 4'h5, 16'h4000, 3'h1, 16'h1, 1, 0); chk(wv[1], 16'h4001);
      op(1, 4'h5, 16'h4004, 3'h2, 16'h2, 0, 0); chk(wv[1], 16'h4002);
      op(0, 4'h5, 16'h4006, 3'h1, 16'h4, 0, 0); chk(wv[0], 16'h4002);
      apb(1, 8'h04, 32'h0008);
      op(1, 4'h5, 16'h4000, 3'h1, 16'h2, 0, 0); chk(wv[1], 16'h4002);
   endtask
   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      ld = 0; xb = 0; rq = 0; errors = 0; checks = 0;
      for (int i = 0; i < 3; i++) begin
         sl[i] = 0; pt[i] = 0; st[i] = 0; md[i] = 0;
      end
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_circ_x;
      t_circ_y;
      t_rev;
      finish_test;
   end
endmodule // mbag_top_bench
`default_nettype wire
